/* hw/ers_rx_status.sv */
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "ers_defines.svh"
module ers_rx_status (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// media-independent receive
	input wire logic i_rx_dv,
	input wire logic i_rx_er,
	input wire logic [3:0] i_rxd,
	// buffer state from the packet store
	input wire logic i_all_buffers_used,
	input wire logic i_fifo_full,
	input wire logic [23:0] i_next_packet_pointer,
	// descriptor write port
	output logic o_desc_we,
	output logic [23:0] o_desc_next_packet_pointer,
	output logic [15:0] o_desc_byte_count,
	output ers_pkg::ers_status_t o_desc_status,
	// receive interrupt
	output logic o_rx_irq,
	// avalon-mm slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);
	import ers_pkg::*;

	ers_state_t state_q;
	logic [15:0] nib_q;
	logic [5:0] pre_q;
	logic [7:0] ipg_q;
	logic [3:0] lo_q;
	logic [15:0] bytes_q;
	logic [15:0] tl_q;
	logic [15:0] opc_q;
	logic [47:0] dest_q;
	logic [31:0] crc_q;
	logic short_ipg_q, code_q, ovr_in_q, long_q;
	logic cevent_q, short_q;
	logic drop_q;
	logic ovr_lock_q;
	logic pure_chk_q, long_chk_q, irq_en_q;
	logic done_q;
	logic ack_q;
	ers_status_t stat_q;

	function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
		end
		return r;
	endfunction : crc_nib

	logic sfd, in_pkt, frame_end, bad_pre, is_ctrl, len_field;
	logic pre_dirty;
	logic [15:0] data_len;
	logic [31:0] crc_next;
	assign sfd = (state_q == ERS_PRE) && i_rx_dv && (i_rxd == `ERS_SFD_NIBBLE);
	assign in_pkt = (state_q == ERS_DATA) && i_rx_dv;
	assign frame_end = (state_q == ERS_DATA) && !i_rx_dv;
	// long check counts preamble bytes as nibble pairs
	assign bad_pre = long_chk_q && (pre_q > 6'(2 * `ERS_MAX_PREAMBLE_BYTES));
	assign pre_dirty = pure_chk_q && (state_q == ERS_PRE) && i_rx_dv && !sfd
		&& (i_rxd != `ERS_PRE_NIBBLE);
	assign crc_next = crc_nib(crc_q, i_rxd);
	assign is_ctrl = (tl_q == `ERS_TYPE_CTRL);
	assign len_field = (tl_q <= `ERS_MAX_LENGTH);
	assign data_len = bytes_q - 16'd18;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= ERS_IDLE;
		end else begin
			unique case (state_q)
				ERS_IDLE: if (i_rx_dv) begin
					// overrun lock discards every frame without any count
					state_q <= ovr_lock_q ? ERS_DROP : ERS_PRE;
				end
				ERS_PRE: if (!i_rx_dv) begin
					state_q <= ERS_IDLE;
				end else if (sfd) begin
					state_q <= ERS_DATA;
				end else if (i_rxd != `ERS_PRE_NIBBLE) begin
					state_q <= pure_chk_q ? ERS_DROP : ERS_PRE;
				end
				ERS_DATA: if (!i_rx_dv) begin
					state_q <= ERS_IDLE;
				end
				ERS_DROP: if (!i_rx_dv) begin
					state_q <= ERS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// a fresh start counts as a long quiet line, so the first frame is kept
			ipg_q <= 8'hff;
			short_ipg_q <= 1'b0;
		end else if (i_rx_dv) begin
			ipg_q <= 8'h00;
			if (state_q == ERS_IDLE) begin
				short_ipg_q <= (ipg_q < 8'(`ERS_MIN_IPG_NIBBLES));
			end
		end else if (ipg_q != 8'hff) begin
			ipg_q <= ipg_q + 8'h01;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pre_q <= 6'h00;
		end else if (state_q != ERS_PRE) begin
			pre_q <= 6'h00;
		end else if (i_rx_dv && !sfd && pre_q != 6'h3f) begin
			pre_q <= pre_q + 6'h01;
		end
	end

	// a dropped or overlong preamble is reported by the next descriptor written
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			drop_q <= 1'b0;
		end else if (pre_dirty || (sfd && bad_pre)) begin
			drop_q <= 1'b1;
		end else if (frame_end) begin
			drop_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			nib_q <= 16'h0000;
			lo_q <= 4'h0;
			bytes_q <= 16'h0000;
			tl_q <= 16'h0000;
			opc_q <= 16'h0000;
			dest_q <= 48'h0;
			crc_q <= 32'hffffffff;
			code_q <= 1'b0;
			ovr_in_q <= 1'b0;
		end else if (sfd) begin
			nib_q <= 16'h0000;
			bytes_q <= 16'h0000;
			crc_q <= 32'hffffffff;
			code_q <= 1'b0;
			ovr_in_q <= 1'b0;
			tl_q <= 16'h0000;
			opc_q <= 16'h0000;
		end else if (in_pkt) begin
			nib_q <= (nib_q == 16'hffff) ? nib_q : nib_q + 16'h0001;
			crc_q <= crc_next;
			if (i_rx_er) begin
				code_q <= 1'b1;
			end
			if (i_all_buffers_used && i_fifo_full) begin
				ovr_in_q <= 1'b1;
			end
			if (!nib_q[0]) begin
				lo_q <= i_rxd;
			end else begin
				bytes_q <= bytes_q + 16'h0001;
				if (bytes_q < 16'd6) begin
					dest_q <= {dest_q[39:0], i_rxd, lo_q};
				end
				if (bytes_q == 16'd12 || bytes_q == 16'd13) begin
					tl_q <= {tl_q[7:0], i_rxd, lo_q};
				end
				if (bytes_q == 16'd14 || bytes_q == 16'd15) begin
					opc_q <= {opc_q[7:0], i_rxd, lo_q};
				end
			end
		end
	end

	// the residue test stands in for comparing fcs bytes one by one
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			long_q <= 1'b0;
		end else if (sfd) begin
			long_q <= 1'b0;
		end else if (in_pkt && (nib_q == 16'(`ERS_LONG_NIBBLES))) begin
			long_q <= 1'b1;
		end
	end

	// history flags survive until the next frame end reports them, whatever that frame's status
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cevent_q <= 1'b0;
			short_q <= 1'b0;
		end else begin
			if (!i_rx_dv && i_rx_er && (i_rxd == `ERS_CARRIER_CODE)) begin
				cevent_q <= 1'b1;
			end else if (frame_end) begin
				cevent_q <= 1'b0;
			end
			if ((state_q == ERS_PRE || state_q == ERS_DROP) && !i_rx_dv) begin
				short_q <= 1'b1;
			end else if (frame_end) begin
				short_q <= bytes_q < 16'(`ERS_MIN_FRAME_BYTES);
			end
		end
	end

	ers_status_t stat_d;
	always_comb begin
		stat_d = 16'h0000;
		stat_d[`ERS_BIT_ODD] = nib_q[0];
		stat_d[`ERS_BIT_FCS] = (crc_q != 32'hdebb20e3);
		stat_d[`ERS_BIT_LONG] = long_q || short_ipg_q || drop_q;
		stat_d[`ERS_BIT_CTRL] = is_ctrl;
		stat_d[`ERS_BIT_PAUSE] = is_ctrl && (opc_q == `ERS_OPC_PAUSE);
		stat_d[`ERS_BIT_OPCODE] = is_ctrl && (opc_q != `ERS_OPC_PAUSE);
		stat_d[`ERS_BIT_BCAST] = (dest_q == 48'hffffffffffff);
		stat_d[`ERS_BIT_MCAST] = dest_q[40] && !stat_d[`ERS_BIT_BCAST];
		stat_d[`ERS_BIT_VLAN] = (tl_q == `ERS_TYPE_VLAN);
		stat_d[`ERS_BIT_LOOR] = (tl_q > `ERS_MAX_LENGTH) && (tl_q < 16'h0600);
		stat_d[`ERS_BIT_LCERR] = len_field && (tl_q != data_len);
		stat_d[`ERS_BIT_CODEV] = code_q;
		stat_d[`ERS_BIT_CEVENT] = cevent_q;
		stat_d[`ERS_BIT_SHORT] = short_q;
		stat_d[`ERS_BIT_OVR] = ovr_in_q;
		stat_d[`ERS_BIT_INTACT] = !(nib_q[0] || stat_d[`ERS_BIT_FCS] || stat_d[`ERS_BIT_LONG]
			|| code_q || ovr_in_q || stat_d[`ERS_BIT_LOOR] || stat_d[`ERS_BIT_LCERR]);
	end

	// descriptor update at the end of every accepted frame
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_desc_we <= 1'b0;
			o_desc_status <= 16'h0000;
			o_desc_byte_count <= 16'h0000;
			o_desc_next_packet_pointer <= 24'h000000;
			stat_q <= 16'h0000;
		end else begin
			o_desc_we <= frame_end;
			if (frame_end) begin
				o_desc_status <= stat_d;
				o_desc_byte_count <= bytes_q;
				o_desc_next_packet_pointer <= i_next_packet_pointer;
				stat_q <= stat_d;
			end
		end
	end

	// istat register: write one clears, set wins over clear
	logic bus_wr, bus_rd;
	// a write lands only on the edge that ends its wait, as the master sees it
	assign bus_wr = i_avs_write && ack_q;
	assign bus_rd = i_avs_read && !ack_q;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			done_q <= 1'b0;
			ovr_lock_q <= 1'b0;
			pure_chk_q <= 1'b0;
			long_chk_q <= 1'b0;
			irq_en_q <= 1'b0;
		end else begin
			if (bus_wr && i_avs_address == `ERS_REG_CTRL && i_avs_byteenable[0]) begin
				irq_en_q <= i_avs_writedata[0];
				pure_chk_q <= i_avs_writedata[1];
				long_chk_q <= i_avs_writedata[2];
			end
			if (o_desc_we) begin
				done_q <= 1'b1;
			end else if (bus_wr && i_avs_address == `ERS_REG_ISTAT && i_avs_byteenable[0]
				&& i_avs_writedata[`ERS_ISTAT_RX_DONE]) begin
				done_q <= 1'b0;
			end
			if (in_pkt && i_all_buffers_used && i_fifo_full) begin
				ovr_lock_q <= 1'b1;
			end else if (bus_wr && i_avs_address == `ERS_REG_ISTAT && i_avs_byteenable[0]
				&& i_avs_writedata[`ERS_ISTAT_RX_OVR]) begin
				ovr_lock_q <= 1'b0;
			end
		end
	end

	// one wait cycle keeps read data registered
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ack_q <= 1'b0;
			o_avs_readdata <= 32'h00000000;
		end else begin
			ack_q <= (i_avs_read || i_avs_write) && !ack_q;
			if (bus_rd) begin
				unique case (i_avs_address)
					`ERS_REG_CTRL: o_avs_readdata <= {29'h0, long_chk_q, pure_chk_q, irq_en_q};
					`ERS_REG_ISTAT: o_avs_readdata <= {30'h0, ovr_lock_q, done_q};
					`ERS_REG_DESC: o_avs_readdata <= {16'h0, o_desc_byte_count};
					`ERS_REG_STAT: o_avs_readdata <= {16'h0, stat_q};
					default: o_avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
	assign o_rx_irq = done_q && irq_en_q;

	chk_desc_after_end: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		frame_end |=> o_desc_we && o_desc_byte_count == $past(bytes_q))
		else $error("descriptor not written after frame end");
	chk_ovr_locks: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		ovr_lock_q && state_q == ERS_IDLE && i_rx_dv |=> state_q == ERS_DROP)
		else $error("frame accepted during overrun lock");
	chk_irq_on_done: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		o_desc_we && irq_en_q |=> o_rx_irq)
		else $error("receive interrupt missing");
	chk_intact_clean: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		o_desc_we |-> !(o_desc_status[15] && (o_desc_status[14] || o_desc_status[3]
		|| o_desc_status[0] || o_desc_status[13] || o_desc_status[12])))
		else $error("intact with error");
	chk_unmapped_zero: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		bus_rd && i_avs_address[1:0] != 2'b00 |=> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_code_viol: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		frame_end && code_q |=> o_desc_we && o_desc_status[`ERS_BIT_CODEV])
		else $error("code violation lost");
	chk_bcast_mcast: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		o_desc_we |-> !(o_desc_status[8] && o_desc_status[9]))
		else $error("broadcast and multicast both set");
	chk_pause_ctrl: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		o_desc_we && o_desc_status[11] |-> o_desc_status[10] && !o_desc_status[6])
		else $error("pause without control");
	chk_pre_drop_kept: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		(pre_dirty || (sfd && bad_pre)) |=> drop_q)
		else $error("preamble drop not remembered");
	chk_drop_reported: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		frame_end && drop_q |=> o_desc_status[`ERS_BIT_LONG]
		&& !o_desc_status[`ERS_BIT_INTACT])
		else $error("dropped event not reported");
endmodule : ers_rx_status

/* hw/ers_defines.svh */
`ifndef ERS_DEFINES_SVH
`define ERS_DEFINES_SVH
`define ERS_BIT_INTACT 15
`define ERS_BIT_ODD 14
`define ERS_BIT_FCS 13
`define ERS_BIT_LONG 12
`define ERS_BIT_PAUSE 11
`define ERS_BIT_CTRL 10
`define ERS_BIT_MCAST 9
`define ERS_BIT_BCAST 8
`define ERS_BIT_VLAN 7
`define ERS_BIT_OPCODE 6
`define ERS_BIT_LOOR 5
`define ERS_BIT_LCERR 4
`define ERS_BIT_CODEV 3
`define ERS_BIT_CEVENT 2
`define ERS_BIT_SHORT 1
`define ERS_BIT_OVR 0
`define ERS_LONG_BIT_TIMES 50000
`define ERS_BITS_PER_NIBBLE 4
`define ERS_LONG_NIBBLES (`ERS_LONG_BIT_TIMES / `ERS_BITS_PER_NIBBLE)
`define ERS_MAX_PREAMBLE_BYTES 11
`define ERS_MAX_LENGTH 16'h05ee
`define ERS_MIN_IPG_NIBBLES 24
`define ERS_MIN_FRAME_BYTES 64
`define ERS_CARRIER_CODE 4'he
`define ERS_SFD_NIBBLE 4'hd
`define ERS_PRE_NIBBLE 4'h5
`define ERS_TYPE_CTRL 16'h8808
`define ERS_TYPE_VLAN 16'h8100
`define ERS_OPC_PAUSE 16'h0001
`define ERS_DESC_BYTES 7
`define ERS_REG_CTRL 4'h0
`define ERS_REG_ISTAT 4'h4
`define ERS_REG_DESC 4'h8
`define ERS_REG_STAT 4'hc
`define ERS_ISTAT_RX_DONE 0
`define ERS_ISTAT_RX_OVR 1
`endif

/* hw/ers_pkg.sv */
package ers_pkg;
	typedef enum logic [1:0] {
		ERS_IDLE = 2'b00,
		ERS_PRE = 2'b01,
		ERS_DATA = 2'b10,
		ERS_DROP = 2'b11
	} ers_state_t;
	typedef logic [15:0] ers_status_t;
endpackage : ers_pkg

/* test/ers_phy_model.sv */
`timescale 1ns/100ps
module ers_phy_model (
	// clock
	input wire logic i_clock,
	// media-independent receive, as the phy drives it
	output logic o_rx_dv,
	output logic o_rx_er,
	output logic [3:0] o_rxd
);
	initial begin
		o_rx_dv = 1'b0;
		o_rx_er = 1'b0;
		o_rxd = 4'h0;
	end
	// one frame: optional carrier event, preamble, sfd, nibbles low first, then a gap
	task automatic send(input logic [7:0] b[$], input bit odd, input bit err, input bit car,
			input int npre, input bit dirty);
		int i;
		if (car) begin
			@(posedge i_clock);
			o_rx_er <= 1'b1;
			o_rxd <= 4'he;
			@(posedge i_clock);
			o_rx_er <= 1'b0;
		end
		// npre preamble nibbles then sfd; dirty spoils one of them
		for (i = 0; i <= npre; i++) begin
			@(posedge i_clock);
			o_rx_dv <= 1'b1;
			o_rxd <= (i == npre) ? 4'hd : ((dirty && i == 3) ? 4'h7 : 4'h5);
		end
		// odd drops the last high nibble
		for (i = 0; i < 2 * b.size() - int'(odd); i++) begin
			@(posedge i_clock);
			o_rxd <= i[0] ? b[i / 2][7:4] : b[i / 2][3:0];
			o_rx_er <= err && (i == 40);
		end
		@(posedge i_clock);
		o_rx_dv <= 1'b0;
		o_rx_er <= 1'b0;
		// released data line keeps changing so a stale nibble never looks valid
		for (i = 0; i < 32; i++) begin
			@(posedge i_clock);
			o_rxd <= ~o_rxd;
		end
	endtask : send
endmodule : ers_phy_model

/* test/ers_rx_status_tb_top.sv */
`timescale 1ns/100ps
module ers_rx_status_tb_top;
	import ers_pkg::*;
	logic i_clock, i_reset_n, rx_dv, rx_er, all_used, fifo_full;
	logic [3:0] rxd, addr;
	logic [23:0] np, d_np;
	logic desc_we, irq, wreq, rd, wr;
	logic [15:0] d_cnt;
	ers_status_t d_st;
	logic [31:0] wdata, rdata, q;
	logic [7:0] fr[$];
	int bad_count, n_tests;
	int we_n = 0;
	int pre_n = 15;
	bit pre_dirty = 1'b0;

	ers_phy_model phy (.i_clock(i_clock), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_rxd(rxd));
	ers_rx_status dut (
		.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_rx_dv(rx_dv), .i_rx_er(rx_er), .i_rxd(rxd),
		.i_all_buffers_used(all_used), .i_fifo_full(fifo_full),
		.i_next_packet_pointer(np),
		.o_desc_we(desc_we), .o_desc_next_packet_pointer(d_np),
		.o_desc_byte_count(d_cnt), .o_desc_status(d_st), .o_rx_irq(irq),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq)
	);

	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	always @(posedge i_clock) if (desc_we === 1'b1) we_n <= we_n + 1;

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// request held until waitrequest is sampled low, data taken at that edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clock);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge i_clock);
			if (wreq === 1'b0) break;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k == 20) begin
			bad_count++;
			$display("[ERR] waitrequest expected 0 seen 1");
			print_verdict();
		end
	endtask : bus

	// frame with crc32 fcs appended; payload opens with the opcode word
	function automatic void mk(input logic [47:0] da, input logic [15:0] lt, input logic [15:0] op,
			input bit badf, input bit odd);
		logic [31:0] c;
		int i, j;
		fr = {};
		for (i = 5; i >= 0; i--) fr.push_back(da[8 * i +: 8]);
		for (i = 0; i < 6; i++) fr.push_back(8'h02 + 8'(i));
		fr.push_back(lt[15:8]);
		fr.push_back(lt[7:0]);
		fr.push_back(op[15:8]);
		fr.push_back(op[7:0]);
		for (i = 2; i < 46; i++) fr.push_back(8'(i));
		c = 32'hffffffff;
		foreach (fr[i]) begin
			c = c ^ {24'h0, fr[i]};
			for (j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
		end
		c = ~c ^ {31'h0, badf};
		for (j = 0; j < 4; j++) fr.push_back(c[8 * j +: 8]);
		if (odd) fr.push_back(8'h0b);
	endfunction : mk

	task automatic rx(input logic [47:0] da, input logic [15:0] lt, input logic [15:0] op,
			input bit badf, input bit odd, input bit err, input bit car,
			input logic [15:0] msk, input logic [15:0] exp, input int want);
		int n0;
		mk(da, lt, op, badf, odd);
		n0 = we_n;
		phy.send(fr, odd, err, car, pre_n, pre_dirty);
		chk("descriptor writes", 32'(want), 32'(we_n - n0));
		if (want == 1) chk("status", {16'h0, exp}, {16'h0, d_st & msk});
	endtask : rx

	task automatic t_regs();
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl reset", 32'h0, q);
		bus(1'b0, 4'h4, 32'h0);
		chk("istat reset", 32'h0, q);
		bus(1'b1, 4'h2, 32'hffffffff);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped read", 32'h0, q);
		bus(1'b1, 4'h0, 32'h1);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h1, q);
	endtask : t_regs

	task automatic t_good();
		np <= 24'h5a3c81;
		rx(48'hffffffffffff, 16'h002e, 16'h0, 0, 0, 0, 0, 16'hfdff, 16'h8100, 1);
		chk("byte count", 32'd64, {16'h0, d_cnt});
		chk("next pointer", 32'h5a3c81, {8'h0, d_np});
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, 4'h4, 32'h1);
		@(posedge i_clock);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask : t_good

	task automatic t_errors();
		rx(48'h020000000001, 16'h002e, 16'h0, 1, 0, 0, 0, 16'ha000, 16'h2000, 1);
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 1, 0, 0, 16'h4000, 16'h4000, 1);
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 0, 1, 0, 16'h8008, 16'h0008, 1);
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 0, 0, 1, 16'h0004, 16'h0004, 1);
		rx(48'h020000000001, 16'h002a, 16'h0, 0, 0, 0, 0, 16'h0030, 16'h0010, 1);
		rx(48'h020000000001, 16'h05f0, 16'h0, 0, 0, 0, 0, 16'h0020, 16'h0020, 1);
	endtask : t_errors

	task automatic t_control();
		rx(48'h0180c2000001, 16'h8808, 16'h0001, 0, 0, 0, 0, 16'h0ec0, 16'h0e00, 1);
		rx(48'h0180c2000001, 16'h8808, 16'h0002, 0, 0, 0, 0, 16'h0ec0, 16'h0640, 1);
		rx(48'h020000000001, 16'h8100, 16'h0000, 0, 0, 0, 0, 16'h0080, 16'h0080, 1);
	endtask : t_control

	task automatic t_preamble();
		bus(1'b1, 4'h0, 32'h7);
		pre_dirty = 1'b1;
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 0, 0, 0, 16'h0, 16'h0, 0);
		pre_dirty = 1'b0;
		pre_n = 30;
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 0, 0, 0, 16'h9002, 16'h1002, 1);
		pre_n = 15;
		bus(1'b1, 4'h0, 32'h1);
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 0, 0, 0, 16'h9002, 16'h8000, 1);
	endtask : t_preamble

	task automatic t_overrun();
		all_used <= 1'b1;
		fifo_full <= 1'b1;
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 0, 0, 0, 16'h0001, 16'h0001, 1);
		all_used <= 1'b0;
		fifo_full <= 1'b0;
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 0, 0, 0, 16'h0, 16'h0, 0);
		bus(1'b0, 4'h4, 32'h0);
		chk("overrun lock", 32'h2, q & 32'h2);
		bus(1'b1, 4'h4, 32'h2);
		rx(48'h020000000001, 16'h002e, 16'h0, 0, 0, 0, 0, 16'h8001, 16'h8000, 1);
	endtask : t_overrun

	initial begin
		{i_reset_n, all_used, fifo_full, rd, wr} = 5'h0;
		{addr, wdata, np, bad_count, n_tests} = '0;
		repeat (12) @(posedge i_clock);
		i_reset_n <= 1'b1;
		t_regs();
		t_good();
		t_errors();
		t_control();
		t_preamble();
		t_overrun();
		print_verdict();
	end
	// whole-run limit
	initial begin
		repeat (100000) @(posedge i_clock);
		bad_count++;
		$display("[ERR] run limit expected done seen timeout");
		print_verdict();
	end
endmodule : ers_rx_status_tb_top
